// *** rtl/cgrb_params.svh ***
// Purpose: constants for the codec global register bank
// Assumes: command bytes are eight bits; read code has bit 7 clear
// Notes: write code is read code with bit 7 set
`ifndef CGRB_PARAMS_SVH
`define CGRB_PARAMS_SVH
`define CGRB_WR_BIT 7
`define CGRB_CMD_PLL 7'h20
`define CGRB_CMD_PCM 7'h22
`define CGRB_CMD_CLK 7'h23
`define CGRB_CMD_RST 7'h24
`define CGRB_CMD_LOOP 7'h25
`define CGRB_CMD_CONF 7'h26
`define CGRB_CMD_GAIN 7'h27
`define CGRB_CMD_SLOT_FIRST 7'h28
`define CGRB_CMD_SLOT_LAST 7'h2D
`define CGRB_CMD_TX_B 7'h28
`define CGRB_CMD_RX_B 7'h29
`define CGRB_CMD_TX_C 7'h2A
`define CGRB_CMD_RX_C 7'h2B
`define CGRB_CMD_TX_D 7'h2C
`define CGRB_CMD_RX_D 7'h2D
`define CGRB_CMD_FSK_FLAG 7'h32
`define CGRB_CMD_FSK_DATA 7'h33
`define CGRB_CMD_FSK_SEIZE 7'h34
`define CGRB_CMD_FSK_MARK 7'h35
`define CGRB_CMD_LM1 7'h2E
`define CGRB_CMD_LM2 7'h2F
`define CGRB_CMD_LMR_LO 7'h30
`define CGRB_CMD_LMR_HI 7'h31
`define CGRB_CMD_FSK_FIRST 7'h32
`define CGRB_CMD_FSK_CTRL 7'h36
`define CGRB_CMD_POL 7'h37
`define CGRB_CMD_HOOK 7'h39
`define CGRB_RST_PCM 8'h40
`define CGRB_RST_CLK 8'h02
`define CGRB_RST_ZERO 8'h00
`define CGRB_HARDWARE_RESET_BIT_BIT 7
`define CGRB_SOFTWARE_RESET_BIT_BIT 5
`define CGRB_MEM_SINGLE_BIT 7
`define CGRB_MEM_EN_BIT 6
`define CGRB_TONE_BP_CENTER_HZ 2100
`define CGRB_TONE_BP_BW_HZ 60
`define CGRB_TONE_BS_BW_HZ 230
`define CGRB_METER_CENTER_HZ 1014
`define CGRB_METER_Q 5
`define CGRB_TG_COEF_DUAL 16'h2000
`endif

// *** rtl/cgrb_pkg.sv ***
// Purpose: types for the codec global register bank
// Assumes: nothing beyond the params header
// Notes: state is one packed struct
package cgrb_pkg;
  typedef logic [7:0] cgrb_byte_t;
  typedef struct packed {
    cgrb_byte_t pll;
    cgrb_byte_t pcm;
    cgrb_byte_t clk;
    cgrb_byte_t rst;
    cgrb_byte_t loop;
    cgrb_byte_t conf;
    cgrb_byte_t gain;
    cgrb_byte_t [5:0] slot;
    cgrb_byte_t lm1;
    cgrb_byte_t lm2;
    cgrb_byte_t lmr_lo;
    cgrb_byte_t lmr_hi;
    cgrb_byte_t [4:0] fsk;
    cgrb_byte_t pol;
    logic [7:0] hook_irq;
    cgrb_byte_t rd_data;
    logic rd_valid;
    logic sw_reset_pulse;
    logic [7:0] hook_s1;
    logic [7:0] hook_s2;
    logic [7:0] hook_s3;
  } cgrb_state_s;
endpackage

// *** rtl/cgrb_bank.sv ***
// Purpose: global configuration and status register bank of a quad PCM codec
// Assumes: command decoder delivers one command byte with a strobe, data with it
// Notes: hook inputs come from pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "cgrb_params.svh"
// ========================================
// register bank
// Function
// - each register except meter result 30H/31H has a read code and a write code with bit 7 set; reset control 24H/A4H.
// - meter result low 30H and high 31H are read only and reset to zero.
// - register 23H holds channel enables in bits 7:4 and clock select in 3:0, default 02H.
// - slot registers 28H to 2DH carry highway select in bit 7 and slot number in bits 6:0.
// - meter config 2 has single shot, enable, select and the top three count bits.
// - hook status at 39H reports off-hook and ground-key per channel; B9H clears pending irqs.
// - conference gain is eight bits at 27H/A7H, default zero.
// - default tone detector bandpass is 2100 Hz centre, 60 Hz bandwidth.
// - default tone detector bandstop is 2100 Hz centre, 230 Hz bandwidth.
// - default meter filter is 1014 Hz centre with Q of 5.
// - the two reserved slots have no commands and no default.
module cgrb_bank (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic [7:0] hook_status_in,
  input wire logic meter_result_valid,
  input wire logic [15:0] meter_result_in,
  output logic [3:0] channel_enable_mask,
  output logic [3:0] clock_select,
  output logic pll_power_down,
  output logic [7:0] conference_gain_value,
  output logic meter_single_shot,
  output logic meter_enable,
  output logic [1:0] meter_select,
  output logic [10:0] meter_count,
  output logic [47:0] slot_config,
  output logic hardware_reset_bit,
  output logic software_reset_bit,
  output logic hook_irq_pending,
  output logic [15:0] tone_bp_center_hz,
  output logic [15:0] tone_bp_bw_hz,
  output logic [15:0] tone_bs_bw_hz,
  output logic [15:0] meter_center_hz,
  output logic [3:0] meter_q
);
  cgrb_pkg::cgrb_state_s s_q;
  cgrb_pkg::cgrb_state_s s_d;
  logic is_wr;
  logic [6:0] code;
  localparam int NUM_CH = 4;
  logic [7:0] hook_change;

  assign is_wr = cmd_byte[`CGRB_WR_BIT];
  assign code = cmd_byte[6:0];

  // ========================================
  // hook change detect per channel; both compare stages sit behind the
  // synchroniser so the first flop feeds nothing but the second
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1)
    begin : g_hook
      // off-hook bit of this channel
      assign hook_change[2*ch] = s_q.hook_s2[2*ch] ^ s_q.hook_s3[2*ch];
      // ground-key bit of this channel
      assign hook_change[2*ch+1] = s_q.hook_s2[2*ch+1] ^ s_q.hook_s3[2*ch+1];
    end
  endgenerate
  // ========================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.sw_reset_pulse = 1'b0;
    s_d.hook_s1 = hook_status_in;
    s_d.hook_s2 = s_q.hook_s1;
    s_d.hook_s3 = s_q.hook_s2;
    if (meter_result_valid)
    begin
      s_d.lmr_lo = meter_result_in[7:0];
      s_d.lmr_hi = meter_result_in[15:8];
    end
    if (cmd_valid && is_wr)
    begin
      unique case (code)
        // pll power-down
        `CGRB_CMD_PLL:
        begin
          s_d.pll = wr_data;
        end
        // pcm coding and framing
        `CGRB_CMD_PCM:
        begin
          s_d.pcm = wr_data;
        end
        // enable mask over clock select
        `CGRB_CMD_CLK:
        begin
          s_d.clk = wr_data;
        end
        // reset bits act from the register on the next cycle
        `CGRB_CMD_RST:
        begin
          s_d.rst = wr_data;
          s_d.sw_reset_pulse = wr_data[`CGRB_SOFTWARE_RESET_BIT_BIT];
        end
        // loopbacks
        `CGRB_CMD_LOOP:
        begin
          s_d.loop = wr_data;
        end
        // conference control
        `CGRB_CMD_CONF:
        begin
          s_d.conf = wr_data;
        end
        // conference gain, full byte
        `CGRB_CMD_GAIN:
        begin
          s_d.gain = wr_data;
        end
        // part b transmit highway and slot
        `CGRB_CMD_TX_B:
        begin
          s_d.slot[0] = wr_data;
        end
        // part b receive highway and slot
        `CGRB_CMD_RX_B:
        begin
          s_d.slot[1] = wr_data;
        end
        // part c transmit highway and slot
        `CGRB_CMD_TX_C:
        begin
          s_d.slot[2] = wr_data;
        end
        // part c receive highway and slot
        `CGRB_CMD_RX_C:
        begin
          s_d.slot[3] = wr_data;
        end
        // part d transmit highway and slot
        `CGRB_CMD_TX_D:
        begin
          s_d.slot[4] = wr_data;
        end
        // part d receive highway and slot
        `CGRB_CMD_RX_D:
        begin
          s_d.slot[5] = wr_data;
        end
        // meter count low byte
        `CGRB_CMD_LM1:
        begin
          s_d.lm1 = wr_data;
        end
        // meter mode bits and count top bits
        `CGRB_CMD_LM2:
        begin
          s_d.lm2 = wr_data;
        end
        // fsk flag length
        `CGRB_CMD_FSK_FLAG:
        begin
          s_d.fsk[0] = wr_data;
        end
        // fsk data length
        `CGRB_CMD_FSK_DATA:
        begin
          s_d.fsk[1] = wr_data;
        end
        // fsk seizure length
        `CGRB_CMD_FSK_SEIZE:
        begin
          s_d.fsk[2] = wr_data;
        end
        // fsk mark length
        `CGRB_CMD_FSK_MARK:
        begin
          s_d.fsk[3] = wr_data;
        end
        // fsk control
        `CGRB_CMD_FSK_CTRL:
        begin
          s_d.fsk[4] = wr_data;
        end
        // interrupt polarity
        `CGRB_CMD_POL:
        begin
          s_d.pol = wr_data;
        end
        // a hook write only clears pending events
        `CGRB_CMD_HOOK:
        begin
          s_d.hook_irq = 8'h00;
        end
        // reserved slots, result bytes and unmapped codes change nothing
        default:
        begin
        end
      endcase
    end
    // events merge after the clear so a same-cycle event survives
    s_d.hook_irq = s_d.hook_irq | hook_change;
    if (cmd_valid && !is_wr)
    begin
      s_d.rd_valid = 1'b1;
      unique case (code)
        // configuration registers
        `CGRB_CMD_PLL:
        begin
          s_d.rd_data = s_q.pll;
        end
        `CGRB_CMD_PCM:
        begin
          s_d.rd_data = s_q.pcm;
        end
        `CGRB_CMD_CLK:
        begin
          s_d.rd_data = s_q.clk;
        end
        `CGRB_CMD_RST:
        begin
          s_d.rd_data = s_q.rst;
        end
        `CGRB_CMD_LOOP:
        begin
          s_d.rd_data = s_q.loop;
        end
        `CGRB_CMD_CONF:
        begin
          s_d.rd_data = s_q.conf;
        end
        `CGRB_CMD_GAIN:
        begin
          s_d.rd_data = s_q.gain;
        end
        // time-slot registers
        `CGRB_CMD_TX_B:
        begin
          s_d.rd_data = s_q.slot[0];
        end
        `CGRB_CMD_RX_B:
        begin
          s_d.rd_data = s_q.slot[1];
        end
        `CGRB_CMD_TX_C:
        begin
          s_d.rd_data = s_q.slot[2];
        end
        `CGRB_CMD_RX_C:
        begin
          s_d.rd_data = s_q.slot[3];
        end
        `CGRB_CMD_TX_D:
        begin
          s_d.rd_data = s_q.slot[4];
        end
        `CGRB_CMD_RX_D:
        begin
          s_d.rd_data = s_q.slot[5];
        end
        // level meter configuration and result
        `CGRB_CMD_LM1:
        begin
          s_d.rd_data = s_q.lm1;
        end
        `CGRB_CMD_LM2:
        begin
          s_d.rd_data = s_q.lm2;
        end
        `CGRB_CMD_LMR_LO:
        begin
          s_d.rd_data = s_q.lmr_lo;
        end
        `CGRB_CMD_LMR_HI:
        begin
          s_d.rd_data = s_q.lmr_hi;
        end
        // fsk timing and control
        `CGRB_CMD_FSK_FLAG:
        begin
          s_d.rd_data = s_q.fsk[0];
        end
        `CGRB_CMD_FSK_DATA:
        begin
          s_d.rd_data = s_q.fsk[1];
        end
        `CGRB_CMD_FSK_SEIZE:
        begin
          s_d.rd_data = s_q.fsk[2];
        end
        `CGRB_CMD_FSK_MARK:
        begin
          s_d.rd_data = s_q.fsk[3];
        end
        `CGRB_CMD_FSK_CTRL:
        begin
          s_d.rd_data = s_q.fsk[4];
        end
        // polarity and synchronised hook status
        `CGRB_CMD_POL:
        begin
          s_d.rd_data = s_q.pol;
        end
        `CGRB_CMD_HOOK:
        begin
          s_d.rd_data = s_q.hook_s2;
        end
        // reserved and unmapped codes give no answer
        default:
        begin
          s_d.rd_data = `CGRB_RST_ZERO;
          s_d.rd_valid = 1'b0;
        end
      endcase
    end
  end

  // ========================================
  // state register; software reset restores configuration defaults
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.pcm <= `CGRB_RST_PCM;
      s_q.clk <= `CGRB_RST_CLK;
    end
    else if (s_q.sw_reset_pulse)
    begin
      // pin history survives so the restart shows no false hook event
      s_q <= '0;
      s_q.pcm <= `CGRB_RST_PCM;
      s_q.clk <= `CGRB_RST_CLK;
      s_q.hook_s1 <= s_d.hook_s1;
      s_q.hook_s2 <= s_d.hook_s2;
      s_q.hook_s3 <= s_d.hook_s3;
      // a hook event in the reset cycle still wins over the clear
      s_q.hook_irq <= hook_change;
    end
    else
      s_q <= s_d;
  end

  // ========================================
  // field outputs
  assign rd_data = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;
  assign channel_enable_mask = s_q.clk[7:4];
  assign clock_select = s_q.clk[3:0];
  assign pll_power_down = s_q.pll[7];
  assign conference_gain_value = s_q.gain;
  assign meter_single_shot = s_q.lm2[`CGRB_MEM_SINGLE_BIT];
  assign meter_enable = s_q.lm2[`CGRB_MEM_EN_BIT];
  assign meter_select = s_q.lm2[5:4];
  assign meter_count = {s_q.lm2[2:0], s_q.lm1};
  assign slot_config = s_q.slot;
  assign hardware_reset_bit = s_q.rst[`CGRB_HARDWARE_RESET_BIT_BIT];
  assign software_reset_bit = s_q.rst[`CGRB_SOFTWARE_RESET_BIT_BIT];
  assign hook_irq_pending = |s_q.hook_irq;
  // fixed default filter tuning, reported for the filter blocks
  assign tone_bp_center_hz = 16'(`CGRB_TONE_BP_CENTER_HZ);
  assign tone_bp_bw_hz = 16'(`CGRB_TONE_BP_BW_HZ);
  assign tone_bs_bw_hz = 16'(`CGRB_TONE_BS_BW_HZ);
  assign meter_center_hz = 16'(`CGRB_METER_CENTER_HZ);
  assign meter_q = 4'(`CGRB_METER_Q);
endmodule
`default_nettype wire

// *** verif/cgrb_host.sv ***
// Purpose: host issuing command bytes
// Assumes: one command per two clocks
// Notes: idle lines carry the inverse value
`timescale 1ns/1ps
`default_nettype none
// ========
// host model
module cgrb_host (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic [7:0] wr_data
);
  initial {cmd_valid, cmd_byte, wr_data} = 17'h00000;
  // hold all through the taking edge, then scramble so stale data never looks valid
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {cmd_valid, cmd_byte, wr_data} = {1'b1, c, d};
    @(posedge sys_clk);
    #1 {cmd_valid, cmd_byte, wr_data} = {1'b0, ~c, ~d};
  endtask
  // sixteen-bit word, high byte first as the tone coefficient wants
  task automatic xfer16(input logic [7:0] c, input logic [15:0] w);
    xfer(c, w[15:8]);
    xfer(c, w[7:0]);
  endtask
endmodule
`default_nettype wire

// *** verif/cgrb_bank_assertions.sv ***
// Purpose: port checks for the register bank
// Assumes: commands one cycle wide
// Notes: bound to every bank
`timescale 1ns/1ps
`default_nettype none
// ========
// checker
module cgrb_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] wr_data,
  input wire logic rd_valid,
  input wire logic [7:0] hook_status_in,
  input wire logic [3:0] channel_enable_mask,
  input wire logic [3:0] clock_select,
  input wire logic [7:0] conference_gain_value,
  input wire logic [47:0] slot_config,
  input wire logic hook_irq_pending
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // one command taken at this edge
  sequence s_cmd(logic [7:0] c);
    cmd_valid && cmd_byte == c;
  endsequence
  AST_RD_ANSWER:
    assert property (cmd_valid && cmd_byte inside {8'h20, [8'h22:8'h37], 8'h39} |=> rd_valid)
      else $error("no read answer");
  AST_RSVD_QUIET:
    assert property (cmd_valid && cmd_byte inside {8'h21, 8'h38} |=> !rd_valid)
      else $error("reserved answered");
  AST_CLK_WR:
    assert property (s_cmd(8'hA3) |=> {channel_enable_mask, clock_select} == $past(wr_data))
      else $error("clock write lost");
  AST_GAIN_WR:
    assert property (s_cmd(8'hA7) |=> conference_gain_value == $past(wr_data))
      else $error("gain write lost");
  AST_SLOT_WR:
    assert property (s_cmd(8'hAD) |=> slot_config[47:40] == $past(wr_data))
      else $error("slot write lost");
  AST_IGNORE:
    assert property (cmd_valid && cmd_byte inside {8'hA1, 8'hB0, 8'hB1, 8'hB8}
      |=> $stable(slot_config) && $stable(conference_gain_value)) else $error("ignored write acted");
  AST_HOOK_EVT:
    assert property ($changed(hook_status_in) |-> ##[1:4] hook_irq_pending)
      else $error("hook event lost");
  AST_SOFT_RST:
    assert property (s_cmd(8'hA4) ##0 wr_data[5]
      |-> ##[1:2] {channel_enable_mask, clock_select} == 8'h02) else $error("soft reset missed");
endmodule
bind cgrb_bank cgrb_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
  .wr_data(wr_data), .rd_valid(rd_valid), .hook_status_in(hook_status_in),
  .channel_enable_mask(channel_enable_mask), .clock_select(clock_select),
  .conference_gain_value(conference_gain_value), .slot_config(slot_config),
  .hook_irq_pending(hook_irq_pending)
);
`default_nettype wire

// *** verif/codec_global_register_bank_bench.sv ***
// Purpose: self-checking bench for the register bank
// Assumes: host model spaces commands two clocks apart
// Notes: model is an array indexed by command code
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value %0t %h %h", $time, a, e); end end
// ========
// bench top
module codec_global_register_bank_bench;
  logic sys_clk, rst, cmd_valid, rd_valid, meter_result_valid, pll_power_down, meter_enable;
  logic meter_single_shot, hardware_reset_bit, software_reset_bit, hook_irq_pending;
  logic [7:0] cmd_byte, wr_data, rd_data, hook_status_in, conference_gain_value, d;
  logic [3:0] channel_enable_mask, clock_select, meter_q;
  logic [1:0] meter_select;
  logic [10:0] meter_count;
  logic [15:0] meter_result_in, tone_bp_center_hz, tone_bp_bw_hz, tone_bs_bw_hz, meter_center_hz;
  logic [47:0] slot_config;
  logic [7:0] m [0:63];
  int n_mismatch, checks_done;
  cgrb_bank dut (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .hook_status_in(hook_status_in), .meter_result_valid(meter_result_valid),
    .meter_result_in(meter_result_in), .channel_enable_mask(channel_enable_mask),
    .clock_select(clock_select), .pll_power_down(pll_power_down),
    .conference_gain_value(conference_gain_value), .meter_single_shot(meter_single_shot),
    .meter_enable(meter_enable), .meter_select(meter_select), .meter_count(meter_count),
    .slot_config(slot_config), .hardware_reset_bit(hardware_reset_bit),
    .software_reset_bit(software_reset_bit), .hook_irq_pending(hook_irq_pending),
    .tone_bp_center_hz(tone_bp_center_hz), .tone_bp_bw_hz(tone_bp_bw_hz),
    .tone_bs_bw_hz(tone_bs_bw_hz), .meter_center_hz(meter_center_hz), .meter_q(meter_q)
  );
  cgrb_host host (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .wr_data(wr_data)
  );
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task rd(input int c, input logic ev);
    host.xfer(c[7:0], 8'h5A);
    `CHK(rd_valid, ev)
    if (ev)
      `CHK(rd_data, m[c])
  endtask
  // whole map; hook status reads back the pin level
  task rd_all;
    m[8'h39] = hook_status_in;
    for (int c = 8'h20; c <= 8'h39; c++)
      rd(c, !(c inside {8'h21, 8'h38}));
  endtask
  task defaults;
    foreach (m[i])
      m[i] = 8'h00;
    m[8'h22] = 8'h40;
    m[8'h23] = 8'h02;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // a hang counts as a mismatch
  initial
  begin
    #50000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h8C47));
    {rst, meter_result_valid, meter_result_in, hook_status_in} = 26'h2000000;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    defaults();
    rd_all();
    $display("reset values done");
    // soft reset bit kept out of random writes
    for (int c = 8'h20; c <= 8'h38; c++)
    begin
      d = 8'($urandom);
      if (c == 8'h24)
        d[5] = 1'b0;
      host.xfer(8'h80 | c[7:0], d);
      if (!(c inside {8'h21, 8'h30, 8'h31, 8'h38}))
        m[c] = d;
    end
    rd_all();
    `CHK({channel_enable_mask, clock_select}, m[8'h23])
    `CHK(conference_gain_value, m[8'h27])
    for (int i = 0; i < 6; i++)
      `CHK(slot_config[i*8 +: 8], m[8'h28 + i])
    `CHK({meter_single_shot, meter_enable, meter_select}, m[8'h2F][7:4])
    `CHK(meter_count, {m[8'h2F][2:0], m[8'h2E]})
    `CHK(pll_power_down, m[8'h20][7])
    `CHK({hardware_reset_bit, software_reset_bit}, {m[8'h24][7], m[8'h24][5]})
    $display("write readback done");
    @(posedge sys_clk);
    #1 meter_result_valid = 1'b1;
    meter_result_in = 16'($urandom);
    {m[8'h31], m[8'h30]} = meter_result_in;
    @(posedge sys_clk);
    #1 meter_result_valid = 1'b0;
    rd(8'h30, 1'b1);
    rd(8'h31, 1'b1);
    hook_status_in = 8'($urandom) | 8'h01;
    repeat (4) @(posedge sys_clk);
    #1 `CHK(hook_irq_pending, 1'b1)
    rd_all();
    host.xfer(8'hB9, 8'h00);
    `CHK(hook_irq_pending, 1'b0)
    `CHK({tone_bp_center_hz, tone_bp_bw_hz}, 32'h0834003C)
    `CHK({tone_bp_center_hz, tone_bs_bw_hz}, 32'h083400E6)
    `CHK({meter_center_hz, meter_q}, 20'h03F65)
    $display("meter hook filter done");
    host.xfer(8'hA4, 8'h20);
    `CHK(software_reset_bit, 1'b1)
    repeat (2) @(posedge sys_clk);
    // tone coefficient word lives outside this bank and must leave it untouched
    host.xfer16(8'h80, 16'h2000);
    defaults();
    rd_all();
    `CHK(hook_irq_pending, 1'b0)
    $display("soft reset done");
    stop_test();
  end
endmodule
`default_nettype wire
